//--- rtl/rafc_jam_ctrl.sv
// Flow decision engine: pause requests in full duplex, timed jamming in half duplex.
//
// The AHB-Lite register port was left to the implementer.
`timescale 1ns/1ps
module rafc_jam_ctrl
  import rafc_pkg::*;
#(
  parameter int FIFO_W = 14
) (
  input  wire logic              hclk,
  input  wire logic              hresetn,
  input  wire logic [FIFO_W-1:0] rx_fifo_bytes,
  input  wire logic              tx_enabled,
  input  wire logic              full_duplex,
  input  wire logic              speed_10,
  input  wire logic              rx_preamble,
  input  wire logic              rx_addr_valid,
  input  wire logic              rx_is_multicast,
  input  wire logic              rx_is_broadcast,
  input  wire logic              rx_is_own_address,
  input  wire logic              pause_done,
  output logic                   pause_req,
  output logic                   pause_zero,
  output logic                   jam,
  rafc_cfg_if.ctrl               cfg
);
  typedef struct packed {
    rafc_state_type st;
    logic           req;
    logic           zero;
    logic           jam;
    logic [12:0]    ticks;
    logic [7:0]     div;
  } rafc_ctl_type;

  rafc_ctl_type s_r;
  rafc_ctl_type s_nxt;
  logic         at_high;
  logic         below_low;
  logic         enabled;
  logic         hit;

  always_comb begin
    at_high   = {2'b0, rx_fifo_bytes} >= ({10'h0, cfg.pause_high_level} << RAFC_UNIT_SHIFT);
    below_low = {2'b0, rx_fifo_bytes} < ({10'h0, cfg.pause_low_level} << RAFC_UNIT_SHIFT);
    enabled   = cfg.trigger_on_any_frame | cfg.trigger_on_multicast |
                cfg.trigger_on_broadcast | cfg.trigger_on_own_address;
    hit = cfg.trigger_on_any_frame ? rx_preamble :
          (rx_addr_valid && ((cfg.trigger_on_multicast && rx_is_multicast) ||
                             (cfg.trigger_on_broadcast && rx_is_broadcast) ||
                             (cfg.trigger_on_own_address && rx_is_own_address)));
    s_nxt = s_r;
    if (s_r.req && pause_done) begin
      s_nxt.req = 1'b0;
    end
    if (full_duplex) begin
      s_nxt.jam   = 1'b0;
      s_nxt.ticks = 13'h0000;
      unique case (s_r.st)
        RAFC_IDLE: begin
          // a single request per crossing of the high level.
          if (cfg.trigger_on_any_frame && at_high && !s_r.req) begin
            s_nxt.req  = 1'b1;
            s_nxt.zero = 1'b0;
            s_nxt.st   = RAFC_PAUSED;
          end
        end
        RAFC_PAUSED: begin
          if (!s_r.req && below_low && enabled) begin
            s_nxt.req  = 1'b1;
            s_nxt.zero = 1'b1;
            s_nxt.st   = RAFC_RESUME;
          end
        end
        RAFC_RESUME: begin
          if (!s_r.req) begin
            s_nxt.st = RAFC_IDLE;
          end
        end
      endcase
    end else begin
      s_nxt.st = RAFC_IDLE;
      if (s_r.jam) begin
        if (s_r.div == 8'(RAFC_TICK_CYCLES - 1)) begin
          s_nxt.div = 8'h00;
          if (s_r.ticks <= 13'd1) begin
            s_nxt.jam = 1'b0;
          end else begin
            s_nxt.ticks = s_r.ticks - 13'd1;
          end
        end else begin
          s_nxt.div = s_r.div + 8'h01;
        end
      end else if (at_high && hit) begin
        s_nxt.jam   = 1'b1;
        s_nxt.div   = 8'h00;
        s_nxt.ticks = rafc_dur_ticks(cfg.jam_duration_sel, speed_10);
      end
    end
    // a disabled transmitter silences everything.
    if (!tx_enabled) begin
      s_nxt.req = 1'b0;
      s_nxt.jam = 1'b0;
      s_nxt.st  = RAFC_IDLE;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_r <= '{st: RAFC_IDLE, req: 1'b0, zero: 1'b0, jam: 1'b0, ticks: 13'h0, div: 8'h00};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign pause_req      = s_r.req;
  assign pause_zero     = s_r.zero;
  assign jam            = s_r.jam;
  assign cfg.state_code = s_r.st;
  assign cfg.jam_active = s_r.jam;
endmodule

//--- rtl/rafc_pkg.sv
// Package of constants and types for the receive FIFO automatic flow controller.
package rafc_pkg;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam logic [7:0]  RAFC_CFG_OFFSET    = 8'hac;
  localparam logic [7:0]  RAFC_STATUS_OFFSET = 8'hb4;
  localparam logic [31:0] RAFC_CFG_RESET     = 32'h0000_0000;
  localparam logic [31:0] RAFC_CFG_WMASK     = 32'h00ff_ffff;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int RAFC_HI_LSB   = 16;
  localparam int RAFC_LO_LSB   = 8;
  localparam int RAFC_DUR_LSB  = 4;
  localparam int RAFC_MULT_BIT = 3;
  localparam int RAFC_BRD_BIT  = 2;
  localparam int RAFC_ADD_BIT  = 1;
  localparam int RAFC_ANY_BIT  = 0;
  localparam int RAFC_UNIT_SHIFT = 6;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int RAFC_CLK_MHZ       = 40;
  localparam int RAFC_TICK_NS       = 100;
  localparam int RAFC_TICK_CYCLES   = (RAFC_TICK_NS * RAFC_CLK_MHZ) / 1000;
  localparam int RAFC_EXTRA10_NS    = 2200;

  typedef enum logic [1:0] {
    RAFC_IDLE,
    RAFC_PAUSED,
    RAFC_RESUME
  } rafc_state_type;

  // Jam durations in 100 ns ticks at 100 Mb/s; 10 Mb/s adds 2.2 us.
  function automatic logic [12:0] rafc_dur_ticks(input logic [3:0] sel, input logic speed10);
    logic [12:0] t;
    t = 13'h0000;
    unique case (sel)
      4'h0: t = 13'd50;
      4'h1: t = 13'd100;
      4'h2: t = 13'd150;
      4'h3: t = 13'd250;
      default: t = 13'((int'(sel) - 3) * 500);
    endcase
    if (speed10) begin
      t = 13'(t + 13'(RAFC_EXTRA10_NS / RAFC_TICK_NS));
    end
    return t;
  endfunction

endpackage

//--- rtl/rafc_cfg_if.sv
// Interface carrying configuration from the register slave to the controller.
`timescale 1ns/1ps
interface rafc_cfg_if;
  logic [7:0] pause_high_level;
  logic [7:0] pause_low_level;
  logic [3:0] jam_duration_sel;
  logic       trigger_on_multicast;
  logic       trigger_on_broadcast;
  logic       trigger_on_own_address;
  logic       trigger_on_any_frame;
  logic [1:0] state_code;
  logic       jam_active;
  modport regs (output pause_high_level, pause_low_level, jam_duration_sel,
                trigger_on_multicast, trigger_on_broadcast, trigger_on_own_address,
                trigger_on_any_frame, input state_code, jam_active);
  modport ctrl (input pause_high_level, pause_low_level, jam_duration_sel,
                trigger_on_multicast, trigger_on_broadcast, trigger_on_own_address,
                trigger_on_any_frame, output state_code, jam_active);
endinterface

//--- rtl/rafc_ahb_regs.sv
// AHB-Lite slave holding the automatic pause configuration register and status.
`timescale 1ns/1ps
module rafc_ahb_regs
  import rafc_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic        hready,
  input  wire logic [31:0] hwdata,
  output logic [31:0]      hrdata,
  rafc_cfg_if.regs         cfg
);
  typedef struct packed {
    logic [31:0] cfg;
    logic        wr_pend;
    logic [7:0]  addr;
    logic [31:0] rdata;
  } rafc_regs_type;

  rafc_regs_type s_r;
  rafc_regs_type s_nxt;

  always_comb begin
    s_nxt = s_r;
    if (s_r.wr_pend && s_r.addr == RAFC_CFG_OFFSET) begin
      s_nxt.cfg = hwdata & RAFC_CFG_WMASK;
    end
    s_nxt.wr_pend = 1'b0;
    if (hsel && hready && htrans[1]) begin
      s_nxt.addr    = haddr[7:0];
      s_nxt.wr_pend = hwrite && (haddr[31:8] == 24'h00_0000);
      s_nxt.rdata   = 32'h0000_0000;
      if (!hwrite && haddr[31:8] == 24'h00_0000) begin
        if (haddr[7:0] == RAFC_CFG_OFFSET) begin
          s_nxt.rdata = s_nxt.cfg;
        end else if (haddr[7:0] == RAFC_STATUS_OFFSET) begin
          s_nxt.rdata = {29'h0, cfg.jam_active, cfg.state_code};
        end
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_r <= '{cfg: RAFC_CFG_RESET, wr_pend: 1'b0, addr: 8'h00, rdata: 32'h0000_0000};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign hrdata                     = s_r.rdata;
  assign cfg.pause_high_level       = s_r.cfg[RAFC_HI_LSB +: 8];
  assign cfg.pause_low_level        = s_r.cfg[RAFC_LO_LSB +: 8];
  assign cfg.jam_duration_sel       = s_r.cfg[RAFC_DUR_LSB +: 4];
  assign cfg.trigger_on_multicast   = s_r.cfg[RAFC_MULT_BIT];
  assign cfg.trigger_on_broadcast   = s_r.cfg[RAFC_BRD_BIT];
  assign cfg.trigger_on_own_address = s_r.cfg[RAFC_ADD_BIT];
  assign cfg.trigger_on_any_frame   = s_r.cfg[RAFC_ANY_BIT];
endmodule

//--- rtl/rafc_top.sv
// Top of the receive FIFO automatic flow controller with its AHB-Lite register slave.
//
// How it works
// - No pause request or jamming while the MAC transmitter is disabled.
// - High level, bits 23:16, in 64-byte units, triggers flow control.
// - Full duplex: one pause frame per high-level crossing, MAC supplies time.
// - Half duplex: matching frames are jammed for the programmed duration.
// - Low level, bits 15:8; falling below it requests a zero-time pause.
// - Zero-time pause only after a nonzero pause went out.
// - Zero-time pause is issued whenever any trigger bit enables control.
// - Bits 7:4 select jam duration; ignored in full duplex.
// - Bit 3 jams multicast frames above the high level, half duplex.
// - Bit 2 jams broadcast frames above the high level, half duplex.
// - Bit 1 jams own-address frames above the high level, half duplex.
// - Bit 0 triggers on any frame, enables pause, overrides bits 3..1.
// - Any-frame in full duplex requests a pause immediately.
// - Duration codes run from 5 us (7.2 us) up to 600 us (602.2 us).
`timescale 1ns/1ps
module rafc_top
  import rafc_pkg::*;
#(
  parameter int FIFO_W = 14
) (
  input  wire logic              hclk,
  input  wire logic              hresetn,
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic              hready,
  input  wire logic [31:0]       hwdata,
  output logic [31:0]            hrdata,
  output logic                   hreadyout,
  output logic                   hresp,
  input  wire logic [FIFO_W-1:0] rx_fifo_bytes,
  input  wire logic              tx_enabled,
  input  wire logic              full_duplex,
  input  wire logic              speed_10,
  input  wire logic              rx_preamble,
  input  wire logic              rx_addr_valid,
  input  wire logic              rx_is_multicast,
  input  wire logic              rx_is_broadcast,
  input  wire logic              rx_is_own_address,
  input  wire logic              pause_done,
  output logic                   pause_req,
  output logic                   pause_zero,
  output logic                   jam
);
  import rafc_pkg::*;

  rafc_cfg_if cfg ();

  // --------------------------------------------------------------------
  // Register slave: always ready, always OKAY; data phase has no wait.
  // --------------------------------------------------------------------
  rafc_ahb_regs u_regs (
    .hclk    (hclk),
    .hresetn (hresetn),
    .hsel    (hsel),
    .haddr   (haddr),
    .htrans  (htrans),
    .hwrite  (hwrite),
    .hready  (hready),
    .hwdata  (hwdata),
    .hrdata  (hrdata),
    .cfg     (cfg)
  );

  rafc_jam_ctrl #(.FIFO_W(FIFO_W)) u_ctrl (
    .hclk              (hclk),
    .hresetn           (hresetn),
    .rx_fifo_bytes     (rx_fifo_bytes),
    .tx_enabled        (tx_enabled),
    .full_duplex       (full_duplex),
    .speed_10          (speed_10),
    .rx_preamble       (rx_preamble),
    .rx_addr_valid     (rx_addr_valid),
    .rx_is_multicast   (rx_is_multicast),
    .rx_is_broadcast   (rx_is_broadcast),
    .rx_is_own_address (rx_is_own_address),
    .pause_done        (pause_done),
    .pause_req         (pause_req),
    .pause_zero        (pause_zero),
    .jam               (jam),
    .cfg               (cfg)
  );

  logic ready_r;
  logic resp_r;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ready_r <= 1'b1;
      resp_r  <= 1'b0;
    end else begin
      ready_r <= 1'b1;
      resp_r  <= 1'b0;
    end
  end
  assign hreadyout = ready_r;
  assign hresp     = resp_r;
endmodule

//--- verif/rafc_checker.sv
// Concurrent checks on the ports of the automatic flow controller top.
`timescale 1ns/1ps
module rafc_checker
  import rafc_pkg::*;
#(
  parameter int FIFO_W = 14
) (
  input wire logic              hclk,
  input wire logic              hresetn,
  input wire logic              hsel,
  input wire logic [31:0]       haddr,
  input wire logic [1:0]        htrans,
  input wire logic              hwrite,
  input wire logic              hready,
  input wire logic [31:0]       hwdata,
  input wire logic [FIFO_W-1:0] rx_fifo_bytes,
  input wire logic              tx_enabled,
  input wire logic              full_duplex,
  input wire logic              speed_10,
  input wire logic              rx_preamble,
  input wire logic              rx_addr_valid,
  input wire logic              rx_is_multicast,
  input wire logic              rx_is_broadcast,
  input wire logic              rx_is_own_address,
  input wire logic              pause_done,
  input wire logic              pause_req,
  input wire logic              pause_zero,
  input wire logic              jam
);
  logic [23:0] cfg_r;
  logic        wr_r;
  logic        sent_r;
  logic [15:0] jam_len_r;
  logic [13:0] hi_b;
  logic [13:0] lo_b;
  assign hi_b = {cfg_r[23:16], 6'h00};
  assign lo_b = {cfg_r[15:8], 6'h00};
  // Shadow of the configuration, snooped from the bus, since the register is internal.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      {cfg_r, wr_r, sent_r, jam_len_r} <= '0;
    end else begin
      wr_r      <= hsel && hready && htrans[1] && hwrite && haddr == {24'h0, RAFC_CFG_OFFSET};
      jam_len_r <= jam ? jam_len_r + 16'h0001 : 16'h0000;
      if (wr_r) cfg_r <= hwdata[23:0];
      if (pause_done && pause_req) sent_r <= !pause_zero;
      if (!tx_enabled) sent_r <= 1'b0;
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  property p_tx_off; !tx_enabled |=> !pause_req && !jam; endproperty
  a_tx_off: assert property (p_tx_off) else $error("output active with transmitter off");
  property p_hold; pause_req && !pause_done && tx_enabled |=> pause_req && $stable(pause_zero);
  endproperty
  a_hold: assert property (p_hold) else $error("pause request dropped early");
  property p_clear; pause_req && pause_done |=> !pause_req; endproperty
  a_clear: assert property (p_clear) else $error("pause request kept after done");
  property p_pause; $rose(pause_req) && !pause_zero |->
    $past(full_duplex && tx_enabled && cfg_r[0] && rx_fifo_bytes >= hi_b); endproperty
  a_pause: assert property (p_pause) else $error("pause without cause");
  property p_zero; $rose(pause_req) && pause_zero |->
    sent_r && $past(rx_fifo_bytes < lo_b && cfg_r[3:0] != 4'h0); endproperty
  a_zero: assert property (p_zero) else $error("zero pause without cause");
  property p_jam; $rose(jam) |-> $past(!full_duplex && tx_enabled && rx_fifo_bytes >= hi_b &&
    (rx_preamble && cfg_r[0] || rx_addr_valid && (rx_is_multicast && cfg_r[3] ||
    rx_is_broadcast && cfg_r[2] || rx_is_own_address && cfg_r[1]))); endproperty
  a_jam: assert property (p_jam) else $error("jam without cause");
  property p_jam_len; $fell(jam) && $past(tx_enabled) && cfg_r[7:4] == 4'h0 && !speed_10 |->
    jam_len_r == 16'h00c8; endproperty
  a_jam_len: assert property (p_jam_len) else $error("jam length wrong");
  property p_fd_jam; full_duplex && !jam |=> !jam; endproperty
  a_fd_jam: assert property (p_fd_jam) else $error("jam in full duplex");
  c_pause: cover property ($rose(pause_req) && !pause_zero);
  c_zero: cover property ($rose(pause_req) && pause_zero);
  c_jam: cover property ($fell(jam));
endmodule
bind rafc_top rafc_checker #(.FIFO_W(FIFO_W)) rafc_checker_i (.hclk, .hresetn, .hsel, .haddr,
  .htrans, .hwrite, .hready, .hwdata, .rx_fifo_bytes, .tx_enabled, .full_duplex, .speed_10,
  .rx_preamble, .rx_addr_valid, .rx_is_multicast, .rx_is_broadcast, .rx_is_own_address,
  .pause_done, .pause_req, .pause_zero, .jam);

//--- verif/rafc_mac_model.sv
// Behavioural MAC transmitter that sends the pause frames it is asked for.
`timescale 1ns/1ps
module rafc_mac_model (
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic [7:0] delay,
  input  wire logic       pause_req,
  input  wire logic       pause_zero,
  output logic            pause_done,
  output logic [7:0]      nonzero_cnt,
  output logic [7:0]      zero_cnt
);
  logic [7:0] wait_r;
  // The frame leaves in the next free window; delay models a busy transmitter.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      {pause_done, wait_r, nonzero_cnt, zero_cnt} <= '0;
    end else begin
      pause_done <= 1'b0;
      wait_r     <= 8'h00;
      if (pause_req && !pause_done) begin
        wait_r <= wait_r + 8'h01;
        if (wait_r >= delay) begin
          pause_done <= 1'b1;
          wait_r     <= 8'h00;
          if (pause_zero) zero_cnt <= zero_cnt + 8'h01;
          else nonzero_cnt <= nonzero_cnt + 8'h01;
        end
      end
    end
  end
endmodule

//--- verif/rafc_top_test.sv
// Self-checking testbench of the receive FIFO automatic flow controller.
`timescale 1ns/1ps
module rafc_top_test;
  import rafc_pkg::*;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, pause_done, pause_req, pause_zero;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [1:0]  htrans;
  logic [13:0] rx_fifo_bytes;
  logic        tx_enabled, full_duplex, speed_10, jam, rx_preamble, rx_addr_valid;
  logic        rx_is_multicast, rx_is_broadcast, rx_is_own_address;
  logic [7:0]  delay, nz_cnt, z_cnt;
  int          err_count, comparisons;
  rafc_top rafc_top_i (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
    .hready(hreadyout), .hwdata, .hrdata, .hreadyout, .hresp, .rx_fifo_bytes, .tx_enabled,
    .full_duplex, .speed_10, .rx_preamble, .rx_addr_valid, .rx_is_multicast, .rx_is_broadcast,
    .rx_is_own_address, .pause_done, .pause_req, .pause_zero, .jam);
  rafc_mac_model rafc_mac_model_i (.hclk, .hresetn, .delay, .pause_req, .pause_zero,
    .pause_done, .nonzero_cnt(nz_cnt), .zero_cnt(z_cnt));
  initial begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end
  task automatic tally_and_finish;
    if (err_count == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t ns: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1; htrans <= 2'h2; haddr <= a; hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  task automatic frame(input logic [4:0] v);
    {rx_preamble, rx_addr_valid, rx_is_multicast, rx_is_broadcast, rx_is_own_address} <= v;
    @(posedge hclk);
    {rx_preamble, rx_addr_valid, rx_is_multicast, rx_is_broadcast, rx_is_own_address} <= 5'h00;
  endtask
  task automatic settle(input logic [7:0] nz, input logic [7:0] z);
    for (int i = 0; i < 200 && !(nz_cnt === nz && z_cnt === z); i++) @(posedge hclk);
    check({16'h0000, nz_cnt, z_cnt}, {16'h0000, nz, z}, "pause frame count");
  endtask
  function automatic int exp_len(input logic [3:0] c, input logic s10);
    int t;
    t = (c < 4'h4) ? (c == 4'h3 ? 250 : 50 * (int'(c) + 1)) : (int'(c) - 3) * 500;
    return (t + (s10 ? 22 : 0)) * 4;
  endfunction
  task automatic jam_len(input int exp);
    int n;
    n = 0;
    for (int i = 0; i < 10 && jam !== 1'b1; i++) @(posedge hclk);
    while (jam === 1'b1 && n < 30000) begin
      n++;
      @(posedge hclk);
    end
    check(32'(n), 32'(exp), "jam length");
  endtask
  task automatic t_regs;
    bus(1'b0, 32'h0000_00ac, 32'h0); check(q, 32'h0000_0000, "config reset");
    bus(1'b1, 32'h0000_00ac, 32'hff7f_ffff);
    bus(1'b0, 32'h0000_00ac, 32'h0); check(q, 32'h007f_ffff, "config bits");
    bus(1'b0, 32'h0000_00c0, 32'h0); check(q, 32'h0000_0000, "unmapped read");
    check({31'h0, hresp}, 32'h0, "bus response");
  endtask
  task automatic t_full;
    full_duplex <= 1'b1; delay <= 8'h0c;
    bus(1'b1, 32'h0000_00ac, 32'h0002_0101);
    repeat (40) @(posedge hclk); settle(0, 0);
    rx_fifo_bytes <= 14'h07f; repeat (40) @(posedge hclk); settle(0, 0);
    rx_fifo_bytes <= 14'h080; settle(1, 0);
    rx_fifo_bytes <= 14'h12c; repeat (40) @(posedge hclk); settle(1, 0);
    bus(1'b0, 32'h0000_00b4, 32'h0); check(q, 32'h0000_0001, "state paused");
    rx_fifo_bytes <= 14'h040; repeat (40) @(posedge hclk); settle(1, 0);
    delay <= 8'h00; rx_fifo_bytes <= 14'h03f; settle(1, 1);
    rx_fifo_bytes <= 14'h080; settle(2, 1);
    rx_fifo_bytes <= 14'h000; settle(2, 2);
  endtask
  task automatic t_tx_off;
    tx_enabled <= 1'b0; rx_fifo_bytes <= 14'h12c;
    repeat (40) @(posedge hclk); settle(2, 2);
    full_duplex <= 1'b0; frame(5'h10); jam_len(0);
    tx_enabled <= 1'b1;
  endtask
  task automatic t_jam;
    logic [3:0] code [4];
    code = '{4'h0, 4'h2, 4'h4, 4'hf};
    for (int k = 0; k < 4; k++) begin
      speed_10 <= k[0];
      bus(1'b1, 32'h0000_00ac, {16'h0002, 8'h00, code[k], 4'(1 << k)});
      frame(k == 0 ? 5'h10 : {2'b01, 3'(1 << (k - 1))});
      jam_len(exp_len(code[k], k[0]));
    end
    bus(1'b1, 32'h0000_00ac, 32'h0002_0108);
    frame(5'h0a); jam_len(0);
    rx_fifo_bytes <= 14'h07f; frame(5'h0c); jam_len(0);
    full_duplex <= 1'b1; rx_fifo_bytes <= 14'h12c; frame(5'h0c); jam_len(0);
    settle(2, 2);
  endtask
  task automatic t_reset;
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    bus(1'b0, 32'h0000_00ac, 32'h0); check(q, 32'h0000_0000, "config after reset");
    settle(0, 0);
  endtask
  initial begin
    {hsel, hwrite, htrans, haddr, hwdata, full_duplex, speed_10, rx_fifo_bytes, delay} = '0;
    {rx_preamble, rx_addr_valid, rx_is_multicast, rx_is_broadcast, rx_is_own_address} = '0;
    err_count = 0; comparisons = 0; tx_enabled = 1'b1; hresetn = 1'b0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_regs(); t_full(); t_tx_off(); t_jam(); t_reset();
    tally_and_finish();
  end
  // The longest jam alone takes some 24000 cycles, so the limit leaves ample margin.
  initial begin
    repeat (60000) @(posedge hclk);
    err_count++;
    tally_and_finish();
  end
endmodule
